// file: design/hti_regs.vh
`ifndef HTI_REGS_VH
`define HTI_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define HTI_ADDR_ERR       8'h03
`define HTI_ADDR_HUM_LO    8'h04
`define HTI_ADDR_HUM_HI    8'h05
`define HTI_ADDR_TMP_LO    8'h06
`define HTI_ADDR_TMP_HI    8'h07
`define HTI_ADDR_RAW_LO    8'h0a
`define HTI_ADDR_RAW_HI    8'h0b
`define HTI_ADDR_CAP_CTRL  8'h2c
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define HTI_ERR_BIT        0
`define HTI_EXT_CAP_BIT    4
`define HTI_INT_CAP_MSB    3
`define HTI_INT_CAP_LSB    0
`define HTI_EXT_CAP_RST    1'b0
`define HTI_INT_CAP_RST    4'h0
`define HTI_RAW_RST        16'h0000
`define HTI_ERR_RST        1'b0
// ----------------------------------------
// bus constants
// ----------------------------------------
`define HTI_DEV_ADDR       7'h7f
`define HTI_REG_COUNT      64
`endif

// file: design/hti_regmem.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// small register image, registered read
// ----------------------------------------
module hti_regmem #(
    parameter AW = 6
) (
    input  wire          mclk,
    input  wire          ce,
    input  wire [AW-1:0] raddr,
    input  wire [7:0]    rbank,    // flat view selected by caller
    output reg  [7:0]    rdata_q
);
    // read data captured on the clock so it is stable during shifting
    always @(posedge mclk) begin
        if (ce) begin
            rdata_q <= rbank;
        end
    end
    wire unused_ok = &{1'b0, raddr};
endmodule
`default_nettype wire

// file: design/hti_i2c_target.v
// Functional notes
// - raw capacitance high byte readable at 0bh
// - bit 4 of 2ch connects external capacitance
// - bits 3-0 of 2ch pick internal capacitance
// - humidity code at 04h low, 05h high
// - temperature code at 06h low, 07h high
// - read uses pointer write, restart, read address
// - read returns pointer byte then increments
// - write: address with bit 0, then pointer
// - byte after pointer stored at pointer
// - further write bytes go to next registers
// - start/stop are sda edges while scl high
// - repeated start accepted without a stop
// - answer only to address 7fh
`timescale 1ns/10ps
`default_nettype none
`include "hti_regs.vh"
module hti_i2c_target (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        ce,
    input  wire        scl_i,             // bus clock pin
    input  wire        sda_i,             // bus data pin
    output wire        sda_o,             // always low when driving
    output wire        sda_oe,            // high while pulling sda low
    input  wire [9:0]  humidity_code,     // corrected humidity result
    input  wire [10:0] temperature_code,  // corrected temperature result
    input  wire [15:0] raw_cap,           // uncorrected capacitance result
    input  wire        raw_cap_valid,     // one-cycle load of raw_cap
    input  wire        det_error_set,     // one-cycle detection error event
    output reg         external_cap_connect,
    output reg  [3:0]  internal_cap_select,
    output reg         det_error_q        // detection error flag
);
    // ----------------------------------------
    // states, one-hot
    // ----------------------------------------
    localparam S_IDLE = 5'b00001;     // wait for start
    localparam S_RX   = 5'b00010;     // shifting a byte in
    localparam S_ACK  = 5'b00100;     // driving our ack, or ending a master ack
    localparam S_TX   = 5'b01000;     // shifting a byte out
    localparam S_MACK = 5'b10000;     // sampling master ack

    // ----------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------
    reg  [1:0] scl_sync_q;            // two flops on scl
    reg  [1:0] sda_sync_q;            // two flops on sda
    reg        scl_last_q;            // previous synchronised scl
    reg        sda_last_q;            // previous synchronised sda
    wire       scl_s = scl_sync_q[1];
    wire       sda_s = sda_sync_q[1];
    wire       scl_rise = scl_s & ~scl_last_q;
    wire       scl_fall = ~scl_s & scl_last_q;
    wire       start_det = scl_s & scl_last_q & sda_last_q & ~sda_s;
    wire       stop_det  = scl_s & scl_last_q & ~sda_last_q & sda_s;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 2'b11;
            sda_sync_q <= 2'b11;
            scl_last_q <= 1'b1;
            sda_last_q <= 1'b1;
        end else if (ce) begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_last_q <= scl_s;
            sda_last_q <= sda_s;
        end
    end

    // ----------------------------------------
    // protocol state
    // ----------------------------------------
    reg [4:0] state_q;
    reg [7:0] shift_q;                // receive/transmit shift register
    reg [3:0] bitcnt_q;               // bits done in current byte
    reg [7:0] ptr_q;                  // register pointer
    reg       addr_phase_q;           // next byte is the address byte
    reg       ptr_phase_q;            // next written byte is the pointer
    reg       rd_mode_q;              // current transfer is a read
    reg       drive_q;                // pulling sda low
    reg [7:0] rdata;                  // read mux
    wire [7:0] rdata_q;               // registered read byte
    reg [15:0] raw_q;                 // held raw capacitance result

    // read mux: reserved bits zero
    always @* begin
        case (ptr_q)
            `HTI_ADDR_ERR:      rdata = {7'h00, det_error_q};
            `HTI_ADDR_HUM_LO:   rdata = humidity_code[7:0];
            `HTI_ADDR_HUM_HI:   rdata = {6'h00, humidity_code[9:8]};
            `HTI_ADDR_TMP_LO:   rdata = temperature_code[7:0];
            `HTI_ADDR_TMP_HI:   rdata = {5'h00, temperature_code[10:8]};
            `HTI_ADDR_RAW_LO:   rdata = raw_q[7:0];
            `HTI_ADDR_RAW_HI:   rdata = raw_q[15:8];
            `HTI_ADDR_CAP_CTRL: rdata = {3'h0, external_cap_connect, internal_cap_select};
            default:            rdata = 8'h00;
        endcase
    end

    // registered read data
    hti_regmem #(
        .AW (8)
    ) u_rdmem (
        .mclk    (mclk),
        .ce      (ce),
        .raddr   (ptr_q),
        .rbank   (rdata),
        .rdata_q (rdata_q)
    );

    // ----------------------------------------
    // raw capacitance holding register
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            raw_q <= `HTI_RAW_RST;
        end else if (ce && raw_cap_valid) begin
            raw_q <= raw_cap;
        end
    end

    // write strobe for a data byte
    wire wr_byte = (state_q == S_RX) && scl_fall && (bitcnt_q == 4'd8)
                   && !addr_phase_q && !ptr_phase_q;
    wire [7:0] wr_data = shift_q;

    // pointer advance, shared by read and write streaming, wraps past ffh
    function [7:0] ptr_step;
        input [7:0] ptr;
        begin
            ptr_step = ptr + 8'h01;
        end
    endfunction

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            external_cap_connect <= `HTI_EXT_CAP_RST;
            internal_cap_select  <= `HTI_INT_CAP_RST;
            det_error_q          <= `HTI_ERR_RST;
        end else if (ce) begin
            if (wr_byte && ptr_q == `HTI_ADDR_CAP_CTRL) begin
                external_cap_connect <= wr_data[`HTI_EXT_CAP_BIT];
                internal_cap_select  <= wr_data[`HTI_INT_CAP_MSB:`HTI_INT_CAP_LSB];
            end
            // set wins over the write-one clear
            if (det_error_set) begin
                det_error_q <= 1'b1;
            end else if (wr_byte && ptr_q == `HTI_ADDR_ERR && wr_data[`HTI_ERR_BIT]) begin
                det_error_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // bus state machine
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= S_IDLE;
            shift_q      <= 8'h00;
            bitcnt_q     <= 4'd0;
            ptr_q        <= 8'h00;
            addr_phase_q <= 1'b0;
            ptr_phase_q  <= 1'b0;
            rd_mode_q    <= 1'b0;
            drive_q      <= 1'b0;
        end else if (ce) begin
            if (stop_det) begin
                state_q <= S_IDLE;
                drive_q <= 1'b0;
            end else if (start_det) begin
                // start or repeated start, pointer kept
                state_q      <= S_RX;
                bitcnt_q     <= 4'd0;
                addr_phase_q <= 1'b1;
                drive_q      <= 1'b0;
            end else begin
                case (state_q)
                    S_RX: begin
                        if (scl_rise && bitcnt_q != 4'd8) begin
                            shift_q  <= {shift_q[6:0], sda_s};
                            bitcnt_q <= bitcnt_q + 4'd1;
                        end else if (scl_fall && bitcnt_q == 4'd8) begin
                            bitcnt_q <= 4'd0;
                            if (addr_phase_q) begin
                                addr_phase_q <= 1'b0;
                                if (shift_q[7:1] == `HTI_DEV_ADDR) begin
                                    rd_mode_q   <= shift_q[0];
                                    ptr_phase_q <= ~shift_q[0];
                                    drive_q     <= 1'b1;
                                    state_q     <= S_ACK;
                                end else begin
                                    state_q <= S_IDLE;
                                end
                            end else begin
                                if (ptr_phase_q) begin
                                    ptr_q       <= shift_q;
                                    ptr_phase_q <= 1'b0;
                                end else begin
                                    ptr_q <= ptr_step(ptr_q);
                                end
                                drive_q <= 1'b1;
                                state_q <= S_ACK;
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            if (rd_mode_q) begin
                                shift_q  <= rdata_q;
                                drive_q  <= ~rdata_q[7];
                                bitcnt_q <= 4'd1;
                                state_q  <= S_TX;
                            end else begin
                                drive_q <= 1'b0;
                                state_q <= S_RX;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (bitcnt_q == 4'd8) begin
                                drive_q <= 1'b0;
                                ptr_q   <= ptr_step(ptr_q);
                                state_q <= S_MACK;
                            end else begin
                                shift_q  <= {shift_q[6:0], 1'b0};
                                drive_q  <= ~shift_q[6];
                                bitcnt_q <= bitcnt_q + 4'd1;
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            // ack continues, nack goes back to idle
                            state_q <= sda_s ? S_IDLE : S_ACK;
                        end
                    end
                    S_IDLE: begin
                        drive_q <= 1'b0;
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // open drain: only ever pull low
    assign sda_o  = 1'b0;
    assign sda_oe = drive_q;
endmodule
`default_nettype wire

// file: dv/hti_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// target pin checks
// ----------------------------------------
module hti_monitor (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       det_error_set,
    input wire logic       external_cap_connect,
    input wire logic [3:0] internal_cap_select,
    input wire logic       det_error_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // master start: sda falls while scl high
    sequence s_start;
        scl_i && $fell(sda_i);
    endsequence
    property p_low;
        sda_o == 1'b0;
    endproperty
    a_low: assert property (p_low) else $error("sda driven high");
    property p_rst;
        $rose(rst_n) |-> !external_cap_connect && internal_cap_select == 4'h0 && !det_error_q;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset value");
    // the device only moves sda while scl is low
    property p_oe;
        $changed(sda_oe) |-> !$past(scl_i, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("sda moved with scl high");
    property p_ext;
        $changed(external_cap_connect) |-> !$past(scl_i, 2);
    endproperty
    a_ext: assert property (p_ext) else $error("ext cap changed off byte end");
    property p_int;
        $changed(internal_cap_select) |-> !$past(scl_i, 2);
    endproperty
    a_int: assert property (p_int) else $error("int cap changed off byte end");
    // a driven low bit stands at least 6 clocks
    property p_hold;
        $rose(sda_oe) |-> sda_oe [*6];
    endproperty
    a_hold: assert property (p_hold) else $error("sda low too short");
    // no drive for 8 clocks after a start
    property p_start;
        s_start |-> !sda_oe [*8];
    endproperty
    a_start: assert property (p_start) else $error("sda driven after start");
    property p_err;
        ce && det_error_set |=> det_error_q;
    endproperty
    a_err: assert property (p_err) else $error("error flag not set");
endmodule
bind hti_i2c_target hti_monitor hti_monitor_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .det_error_set(det_error_set), .external_cap_connect(external_cap_connect),
    .internal_cap_select(internal_cap_select), .det_error_q(det_error_q));
`default_nettype wire

// file: dv/hti_mstr.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// bus master model, open drain sda
// ----------------------------------------
module hti_mstr (
    input  wire logic mclk,
    output var logic  scl,
    output var logic  pull,   // high while pulling sda low
    input  wire logic sda
);
    initial scl = 1'b1;
    initial pull = 1'b0;
    // wait n clocks, then step off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // start and repeated start alike, long low phase first
    task automatic start();
        wt(1);
        pull = 1'b0;
        wt(7);
        scl = 1'b1;
        wt(4);
        pull = 1'b1;
        wt(4);
        scl = 1'b0;
    endtask
    // one bit out and one back, 8 clocks a bit
    task automatic bit_io(input logic b, output logic r);
        wt(1);
        pull = !b;
        wt(3);
        scl = 1'b1;
        wt(4);
        r = sda;
        scl = 1'b0;
    endtask
    // byte msb first, then the ninth bit
    task automatic xfer(input logic [7:0] d, input logic nb, output logic [7:0] r,
                        output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(nb, a);
    endtask
    // sda rises while scl high
    task automatic stop();
        wt(1);
        pull = 1'b1;
        wt(3);
        scl = 1'b1;
        wt(4);
        pull = 1'b0;
        wt(8);
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic            mclk = 1'b0;
    logic            rst_n = 1'b0;
    logic            rcv = 1'b0;      // raw result strobe
    logic            des = 1'b0;      // error event strobe
    logic [9:0]      hum = 10'h2a5;
    logic [10:0]     tmp = 11'h5c3;
    logic [15:0]     raw = 16'hbeef;
    logic            scl;
    logic            pull;
    logic            sda_oe;
    logic            ext;
    logic [3:0]      isel;
    logic            err;
    wire logic       sda = !(pull | sda_oe);  // pull-up unless pulled
    int              mismatches = 0;
    int              num_checks = 0;
    logic [7:0]      q [4];
    always #12.5 mclk = ~mclk;
    hti_mstr hti_mstr_inst (.mclk(mclk), .scl(scl), .pull(pull), .sda(sda));
    hti_i2c_target hti_i2c_target_inst (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
        .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .humidity_code(hum),
        .temperature_code(tmp), .raw_cap(raw), .raw_cap_valid(rcv), .det_error_set(des),
        .external_cap_connect(ext), .internal_cap_select(isel), .det_error_q(err));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    // start, address for writing, pointer
    task automatic head(input logic [7:0] p);
        logic [7:0] r;
        logic       a;
        hti_mstr_inst.start();
        hti_mstr_inst.xfer(8'hfe, 1'b1, r, a);
        chk("addr ack", 8'h00, {7'h0, a});
        hti_mstr_inst.xfer(p, 1'b1, r, a);
        chk("ptr ack", 8'h00, {7'h0, a});
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1,
                      input int n);
        logic [7:0] r;
        logic       a;
        head(p);
        hti_mstr_inst.xfer(d0, 1'b1, r, a);
        if (n > 1)
            hti_mstr_inst.xfer(d1, 1'b1, r, a);
        chk("data ack", 8'h00, {7'h0, a});
        hti_mstr_inst.stop();
    endtask
    // pointer, repeated start, n bytes out
    task automatic rd(input logic [7:0] p, input int n);
        logic a;
        head(p);
        hti_mstr_inst.start();
        hti_mstr_inst.xfer(8'hff, 1'b1, q[0], a);
        chk("rd ack", 8'h00, {7'h0, a});
        for (int i = 0; i < n; i++)
            hti_mstr_inst.xfer(8'hff, i == n - 1, q[i], a);
        hti_mstr_inst.stop();
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        final_report();
    end
    initial begin
        logic a;
        int   rh;
        int   tc;
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        rd(8'h0a, 2);
        chk("raw hi", 8'h00, q[1]);
        rd(8'h2c, 1);
        chk("ctrl", 8'h00, q[0]);
        $display("test reset done");
        wr(8'h2b, 8'hee, 8'hfa, 2);
        chk("ext pin", 8'h01, {7'h0, ext});
        chk("int pin", 8'h0a, {4'h0, isel});
        rd(8'h2b, 2);
        chk("unmapped", 8'h00, q[0]);
        chk("ctrl", 8'h1a, q[1]);
        $display("test write done");
        rd(8'h04, 4);
        chk("hum lo", hum[7:0], q[0]);
        chk("hum hi", {6'h0, hum[9:8]}, q[1]);
        chk("tmp lo", tmp[7:0], q[2]);
        chk("tmp hi", {5'h0, tmp[10:8]}, q[3]);
        // host side scaling of the codes just read back
        rh = (int'({q[1][1:0], q[0]}) * 100) >> 10;
        tc = (int'({q[3][2:0], q[2]}) - (1024 - 250)) / 10;
        chk("rh pct", 8'h42, 8'(rh));
        chk("temp degc", 8'h46, 8'(tc));
        $display("test results done");
        @(posedge mclk);
        #1 rcv = 1'b1;
        des = 1'b1;
        @(posedge mclk);
        #1 rcv = 1'b0;
        des = 1'b0;
        raw = 16'h1234;
        rd(8'h0a, 2);
        chk("raw lo", 8'hef, q[0]);
        chk("raw hi", 8'hbe, q[1]);
        rd(8'h03, 1);
        chk("flag", 8'h01, q[0]);
        wr(8'h03, 8'hff, 8'h00, 1);
        chk("flag pin", 8'h00, {7'h0, err});
        $display("test latch done");
        hti_mstr_inst.start();
        hti_mstr_inst.xfer(8'hfc, 1'b1, q[0], a);
        chk("no ack", 8'h01, {7'h0, a});
        hti_mstr_inst.stop();
        $display("test address done");
        // reset again in mid-run, controls go back to their defaults
        @(posedge mclk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 rst_n = 1'b1;
        chk("ext rst", 8'h00, {7'h0, ext});
        repeat (4) @(posedge mclk);
        rd(8'h2c, 1);
        chk("ctrl rst", 8'h00, q[0]);
        $display("test reset again done");
        final_report();
    end
endmodule
`default_nettype wire
